// *** common/lfc_pkg.sv ***
// Shared constants and types for both ends of the LF tag air link codec.
// Assumes both ends run on one 20 MHz ref_clk; carrier period is derived.
package lfc_pkg;
	localparam int CLK_NS = 50;
	localparam int TC_NS = 7450;
	localparam int TC_CYC = (TC_NS + CLK_NS / 2) / CLK_NS;
	localparam int PULSE_OFF_TC = 6;
	localparam int ZERO_MIN_TC = 18;
	localparam int ZERO_MAX_TC = 22;
	localparam int ONE_MIN_TC = 26;
	localparam int ONE_MAX_TC = 30;
	localparam int CV_MIN_TC = 34;
	localparam int CV_MAX_TC = 38;
	localparam int STOP_MIN_TC = 42;
	localparam int ZERO_TX_TC = 20;
	localparam int ONE_TX_TC = 28;
	localparam int CV_TX_TC = 36;
	localparam int STOP_TX_TC = 44;
	localparam int BIT_TC = 32;
	localparam int TFP1_TC = 209;
	localparam int TFP1_MAX_TC = 213;
	localparam int REQ_GAP_TC = 150;
	localparam int QUIET_GAP_TC = STOP_MIN_TC + REQ_GAP_TC;
	localparam int EMPTY_SLOT_TC = TFP1_MAX_TC + 3 * BIT_TC;
	localparam int RESP_IDLE_TC = 2 * BIT_TC;
	localparam int RESP_GAP_TC = REQ_GAP_TC + RESP_IDLE_TC;
	localparam int SETTLE_NS = 2330000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int NVM_NS = 20000000;
	localparam int NVM_CYC = (NVM_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] RESP_SOF = 3'h3;
	localparam int RESP_SOF_LEN = 3;
	typedef enum logic [2:0] {
		CODE_BIPHASE, CODE_MANCH, CODE_DUAL, CODE_MANCH_HALF,
		CODE_MANCH_DBL, CODE_BIPH_HALF, CODE_BIPH_DBL
	} lfc_code_t;
endpackage : lfc_pkg

// *** common/lfc_link_if.sv ***
// Air link between reader end and tag end, as two digital levels.
// Assumes both ends share ref_clk; no clocking block.
`timescale 1ns/1ns
`default_nettype none
interface lfc_link_if;
	logic field_on;
	logic load_mod;
	modport tag (input field_on, output load_mod);
	modport rdr (output field_on, input load_mod);
endinterface : lfc_link_if
`default_nettype wire

// *** hdl/lfc_tag_end.sv ***
// Tag end: downlink pulse interval decoder, turnaround timing, uplink coder.
// Assumes field_on comes from logic on ref_clk, so it is not synchronised.
`timescale 1ns/1ns
`default_nettype none
module lfc_tag_end #(
	parameter int TX_W = 64,
	parameter int NVM_WAIT_CYC = lfc_pkg::NVM_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	lfc_link_if.tag link,
	output logic rx_sof,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_eof,
	output logic rx_err,
	output logic slot_advance,
	input wire logic tx_start,
	input wire lfc_pkg::lfc_code_t tx_code,
	input wire logic tx_nvm,
	input wire logic [TX_W-1:0] tx_data,
	input wire logic [7:0] tx_len,
	output logic tx_ready,
	output logic tx_busy
);
	localparam int NW = $clog2(NVM_WAIT_CYC + 1);
	typedef enum logic [2:0] {
		SYM_ZERO, SYM_ONE, SYM_CV, SYM_STOP, SYM_BAD
	} lfc_sym_t;
	typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_SOF_CV, RX_DATA} lfc_rx_t;
	typedef enum logic [1:0] {W_NONE, W_RESP, W_SLOT} lfc_wait_t;

	logic [7:0] div_ff;
	logic tc_tick;
	logic fld_ff;
	logic fall;
	logic [7:0] ivl_ff;
	lfc_rx_t rx_ff;
	lfc_sym_t sym;
	logic sof_ff;
	logic bit_v_ff;
	logic bit_ff;
	logic eof_ff;
	logic err_ff;
	logic [7:0] wt_ff;
	lfc_wait_t wkind_ff;
	logic slot_ff;
	logic resp_ok_ff;
	logic [NW-1:0] nvm_cnt_ff;
	logic pend_ff;
	lfc_pkg::lfc_code_t code_ff;
	logic nvm_ff;
	logic [TX_W+2:0] sh_ff;
	logic [8:0] cnt_ff;
	logic busy_ff;
	logic phase_ff;
	logic [5:0] hcnt_ff;
	logic lvl_ff;
	logic biph;
	logic [5:0] half_tc;
	logic go;

	function automatic lfc_sym_t classify(input logic [7:0] n);
		if (n >= 8'(lfc_pkg::ZERO_MIN_TC) && n <= 8'(lfc_pkg::ZERO_MAX_TC))
			return SYM_ZERO;
		if (n >= 8'(lfc_pkg::ONE_MIN_TC) && n <= 8'(lfc_pkg::ONE_MAX_TC))
			return SYM_ONE;
		if (n >= 8'(lfc_pkg::CV_MIN_TC) && n <= 8'(lfc_pkg::CV_MAX_TC))
			return SYM_CV;
		if (n >= 8'(lfc_pkg::STOP_MIN_TC))
			return SYM_STOP;
		return SYM_BAD;
	endfunction : classify

	// Intervals are counted in carrier periods made from ref_clk
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			div_ff <= '0;
		else if (tc_tick)
			div_ff <= '0;
		else
			div_ff <= div_ff + 8'h01;
	assign tc_tick = (div_ff == 8'(lfc_pkg::TC_CYC - 1));

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			fld_ff <= 1'b1;
		else
			fld_ff <= link.field_on;
	assign fall = fld_ff & ~link.field_on;
	assign sym = classify(ivl_ff);

	// Decoder stays live during replies, so a new frame is never missed
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			ivl_ff <= '0;
			rx_ff <= RX_IDLE;
			sof_ff <= 1'b0;
			bit_v_ff <= 1'b0;
			bit_ff <= 1'b0;
			eof_ff <= 1'b0;
			err_ff <= 1'b0;
		end
		else
		begin
			sof_ff <= 1'b0;
			bit_v_ff <= 1'b0;
			eof_ff <= 1'b0;
			err_ff <= 1'b0;
			if (fall)
			begin
				ivl_ff <= '0;
				unique case (rx_ff)
					RX_IDLE: rx_ff <= RX_ARMED;
					RX_ARMED:
						if (sym == SYM_ZERO)
							rx_ff <= RX_SOF_CV;
						else
							err_ff <= 1'b1;
					RX_SOF_CV:
						if (sym == SYM_CV)
						begin
							rx_ff <= RX_DATA;
							sof_ff <= 1'b1;
						end
						else
						begin
							rx_ff <= RX_ARMED;
							err_ff <= 1'b1;
						end
					RX_DATA:
						if (sym == SYM_ZERO || sym == SYM_ONE)
						begin
							bit_v_ff <= 1'b1;
							bit_ff <= (sym == SYM_ONE);
						end
						else if (sym == SYM_STOP)
						begin
							eof_ff <= 1'b1;
							rx_ff <= RX_IDLE;
						end
						else
						begin
							err_ff <= 1'b1;
							rx_ff <= RX_ARMED;
						end
				endcase
			end
			else if (tc_tick)
			begin
				if (ivl_ff != 8'hFF)
					ivl_ff <= ivl_ff + 8'h01;
				// A lone pulse followed by silence is a bare end of frame
				if (rx_ff == RX_ARMED && ivl_ff == 8'(lfc_pkg::STOP_MIN_TC))
				begin
					eof_ff <= 1'b1;
					rx_ff <= RX_IDLE;
				end
				if (rx_ff == RX_DATA && ivl_ff == 8'hFE)
				begin
					err_ff <= 1'b1;
					rx_ff <= RX_IDLE;
				end
			end
		end

	// Turnaround timer runs from the last falling edge seen
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			wt_ff <= '0;
			wkind_ff <= W_NONE;
			slot_ff <= 1'b0;
			resp_ok_ff <= 1'b0;
		end
		else
		begin
			slot_ff <= 1'b0;
			if (fall)
			begin
				wt_ff <= '0;
				resp_ok_ff <= 1'b0;
				if (rx_ff == RX_DATA && sym == SYM_STOP)
					wkind_ff <= W_RESP;
				else if (wkind_ff == W_RESP)
					wkind_ff <= W_RESP;
				else if (rx_ff == RX_IDLE)
					wkind_ff <= W_SLOT;
				else
					wkind_ff <= W_NONE;
			end
			else if (go)
				resp_ok_ff <= 1'b0;
			else if (tc_tick && wkind_ff != W_NONE)
			begin
				if (wt_ff == 8'(lfc_pkg::TFP1_TC - 1))
				begin
					wkind_ff <= W_NONE;
					resp_ok_ff <= (wkind_ff == W_RESP);
					slot_ff <= (wkind_ff == W_SLOT);
				end
				else
					wt_ff <= wt_ff + 8'h01;
			end
		end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			nvm_cnt_ff <= '0;
		else if (fall)
			nvm_cnt_ff <= '0;
		else if (nvm_cnt_ff != NW'(NVM_WAIT_CYC))
			nvm_cnt_ff <= nvm_cnt_ff + NW'(1);

	assign biph = (code_ff == lfc_pkg::CODE_BIPHASE)
		|| (code_ff == lfc_pkg::CODE_BIPH_HALF)
		|| (code_ff == lfc_pkg::CODE_BIPH_DBL);

	always_comb
	begin
		half_tc = 6'(lfc_pkg::BIT_TC / 2);
		if (code_ff == lfc_pkg::CODE_DUAL
			|| code_ff == lfc_pkg::CODE_MANCH_HALF
			|| code_ff == lfc_pkg::CODE_BIPH_HALF)
			half_tc = 6'(lfc_pkg::BIT_TC);
		else if (code_ff == lfc_pkg::CODE_MANCH_DBL
			|| code_ff == lfc_pkg::CODE_BIPH_DBL)
			half_tc = 6'(lfc_pkg::BIT_TC / 4);
	end

	// Standard mode streams at will; framed replies wait for turnaround
	assign go = pend_ff && !busy_ff && (code_ff == lfc_pkg::CODE_BIPHASE
		|| (resp_ok_ff && (!nvm_ff
		|| nvm_cnt_ff == NW'(NVM_WAIT_CYC))));

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			pend_ff <= 1'b0;
			code_ff <= lfc_pkg::CODE_BIPHASE;
			nvm_ff <= 1'b0;
			sh_ff <= '0;
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			phase_ff <= 1'b0;
			hcnt_ff <= '0;
			lvl_ff <= 1'b0;
		end
		else if (tx_start && tx_ready)
		begin
			pend_ff <= 1'b1;
			code_ff <= tx_code;
			nvm_ff <= tx_nvm;
			if (tx_code == lfc_pkg::CODE_BIPHASE)
			begin
				sh_ff <= {3'h0, tx_data};
				cnt_ff <= {1'b0, tx_len};
			end
			else
			begin
				sh_ff <= {tx_data, lfc_pkg::RESP_SOF};
				cnt_ff <= {1'b0, tx_len} + 9'(lfc_pkg::RESP_SOF_LEN);
			end
		end
		else if (go)
		begin
			pend_ff <= 1'b0;
			busy_ff <= (cnt_ff != 9'h000);
			phase_ff <= 1'b0;
			hcnt_ff <= '0;
			if (cnt_ff != 9'h000)
				lvl_ff <= biph ? ~lvl_ff : sh_ff[0];
		end
		else if (busy_ff && tc_tick)
		begin
			if (hcnt_ff == half_tc - 6'h01)
			begin
				hcnt_ff <= '0;
				if (!phase_ff)
				begin
					phase_ff <= 1'b1;
					lvl_ff <= biph ? lvl_ff ^ ~sh_ff[0] : ~sh_ff[0];
				end
				else
				begin
					phase_ff <= 1'b0;
					sh_ff <= sh_ff >> 1;
					cnt_ff <= cnt_ff - 9'h001;
					if (cnt_ff <= 9'h001)
					begin
						busy_ff <= 1'b0;
						lvl_ff <= 1'b0;
					end
					else
						lvl_ff <= biph ? ~lvl_ff : sh_ff[1];
				end
			end
			else
				hcnt_ff <= hcnt_ff + 6'h01;
		end

	assign link.load_mod = lvl_ff;
	assign tx_ready = !pend_ff && !busy_ff;
	assign tx_busy = busy_ff;
	assign rx_sof = sof_ff;
	assign rx_bit_valid = bit_v_ff;
	assign rx_bit = bit_ff;
	assign rx_eof = eof_ff;
	assign rx_err = err_ff;
	assign slot_advance = slot_ff;
endmodule : lfc_tag_end
`default_nettype wire

// *** hdl/lfc_reader_end.sv ***
// Reader end: pulse interval request sender and request spacing guard.
// Assumes load_mod comes from logic on ref_clk; field is on from reset.
`timescale 1ns/1ns
`default_nettype none
module lfc_reader_end #(
	parameter int REQ_W = 64,
	parameter int SETTLE_WAIT_CYC = lfc_pkg::SETTLE_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	lfc_link_if.rdr link,
	input wire logic req_start,
	input wire logic req_lone_eof,
	input wire logic req_quiet,
	input wire logic [REQ_W-1:0] req_data,
	input wire logic [7:0] req_len,
	output logic req_ready,
	output logic resp_active,
	output logic resp_end
);
	localparam int SW = $clog2(SETTLE_WAIT_CYC + 1);
	typedef enum logic [2:0] {
		R_IDLE, R_SOF0, R_SOFCV, R_DATA, R_STOP, R_TAIL
	} lfc_rph_t;

	logic [7:0] div_ff;
	logic tc_tick;
	logic [SW-1:0] settle_ff;
	lfc_rph_t ph_ff;
	logic [5:0] t_ff;
	logic [5:0] target;
	logic [REQ_W-1:0] sh_ff;
	logic [7:0] cnt_ff;
	logic quiet_ff;
	logic fld_ff;
	logic take;
	logic eof_edge;
	logic lm_ff;
	logic lm_edge;
	logic [6:0] idle_ff;
	logic act_ff;
	logic end_ff;
	logic [8:0] guard_ff;

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			div_ff <= '0;
		else if (tc_tick)
			div_ff <= '0;
		else
			div_ff <= div_ff + 8'h01;
	assign tc_tick = (div_ff == 8'(lfc_pkg::TC_CYC - 1));

	// Long count; shorten SETTLE_WAIT_CYC in simulation
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			settle_ff <= '0;
		else if (settle_ff != SW'(SETTLE_WAIT_CYC))
			settle_ff <= settle_ff + SW'(1);

	assign take = req_start && req_ready;
	assign eof_edge = (take && req_lone_eof)
		|| (ph_ff == R_STOP && tc_tick && t_ff == target - 6'h01);

	always_comb
	begin
		target = '0;
		unique case (ph_ff)
			R_SOF0: target = 6'(lfc_pkg::ZERO_TX_TC);
			R_SOFCV: target = 6'(lfc_pkg::CV_TX_TC);
			R_DATA: target = sh_ff[0] ? 6'(lfc_pkg::ONE_TX_TC)
				: 6'(lfc_pkg::ZERO_TX_TC);
			R_STOP: target = 6'(lfc_pkg::STOP_TX_TC);
			R_IDLE, R_TAIL: target = '0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			ph_ff <= R_IDLE;
			t_ff <= '0;
			sh_ff <= '0;
			cnt_ff <= '0;
			quiet_ff <= 1'b0;
		end
		else if (take)
		begin
			ph_ff <= req_lone_eof ? R_TAIL : R_SOF0;
			t_ff <= '0;
			sh_ff <= req_data;
			cnt_ff <= req_len;
			quiet_ff <= req_quiet;
		end
		else if (tc_tick && ph_ff != R_IDLE)
		begin
			if (ph_ff == R_TAIL)
			begin
				if (t_ff == 6'(lfc_pkg::PULSE_OFF_TC - 1))
					ph_ff <= R_IDLE;
				else
					t_ff <= t_ff + 6'h01;
			end
			else if (t_ff == target - 6'h01)
			begin
				t_ff <= '0;
				unique case (ph_ff)
					R_SOF0: ph_ff <= R_SOFCV;
					R_SOFCV: ph_ff <= (cnt_ff == 8'h00) ? R_STOP : R_DATA;
					R_DATA:
					begin
						sh_ff <= sh_ff >> 1;
						cnt_ff <= cnt_ff - 8'h01;
						if (cnt_ff == 8'h01)
							ph_ff <= R_STOP;
					end
					R_STOP: ph_ff <= R_TAIL;
					R_IDLE, R_TAIL: ph_ff <= ph_ff;
				endcase
			end
			else
				t_ff <= t_ff + 6'h01;
		end

	// Full carrier stop; a fixed off time sits inside the allowed span
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			fld_ff <= 1'b1;
		else
			fld_ff <= !(ph_ff != R_IDLE
				&& t_ff < 6'(lfc_pkg::PULSE_OFF_TC));
	assign link.field_on = fld_ff;

	// Reply is over after more than two idle bit periods
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			lm_ff <= 1'b0;
			idle_ff <= '0;
			act_ff <= 1'b0;
			end_ff <= 1'b0;
		end
		else
		begin
			lm_ff <= link.load_mod;
			end_ff <= 1'b0;
			if (lm_edge)
			begin
				idle_ff <= '0;
				act_ff <= 1'b1;
			end
			else if (tc_tick && act_ff)
			begin
				if (idle_ff == 7'(lfc_pkg::RESP_IDLE_TC))
				begin
					act_ff <= 1'b0;
					end_ff <= 1'b1;
				end
				else
					idle_ff <= idle_ff + 7'h01;
			end
		end
	assign lm_edge = lm_ff ^ link.load_mod;

	// One guard: an end of frame reloads it, a reply edge only raises it
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			guard_ff <= '0;
		else if (eof_edge)
			guard_ff <= (quiet_ff && !(take && req_lone_eof))
				? 9'(lfc_pkg::QUIET_GAP_TC)
				: 9'(lfc_pkg::EMPTY_SLOT_TC);
		else if (lm_edge && guard_ff < 9'(lfc_pkg::RESP_GAP_TC))
			guard_ff <= 9'(lfc_pkg::RESP_GAP_TC);
		else if (tc_tick && guard_ff != 9'h000)
			guard_ff <= guard_ff - 9'h001;

	assign req_ready = (settle_ff == SW'(SETTLE_WAIT_CYC))
		&& ph_ff == R_IDLE && guard_ff == 9'h000 && !act_ff;
	assign resp_active = act_ff;
	assign resp_end = end_ff;
endmodule : lfc_reader_end
`default_nettype wire

// *** dv/lfc_link_asserts.sv ***
// Checker for the air link: downlink pulse timing, uplink reply timing.
// Assumes one ref_clk for both ends; placed beside the link interface.
`timescale 1ns/1ns
`default_nettype none
module lfc_link_asserts #(
	parameter int SETTLE_WAIT_CYC = lfc_pkg::SETTLE_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic field_on,
	input wire logic load_mod
);
	localparam int TC = lfc_pkg::TC_CYC;
	localparam int SAT = 1000 * TC;
	logic fo_q_ff;
	logic lm_q_ff;
	logic seen_ff;
	logic stop_ff;
	logic sof0_ff;
	int fgap_ff;
	int lgap_ff;
	logic fell_now;
	logic is_zero;
	logic is_stop;
	assign fell_now = fo_q_ff && !field_on;
	assign is_zero = fgap_ff >= 18 * TC - 1 && fgap_ff <= 22 * TC;
	// The first edge after reset opens a frame like a stop would
	assign is_stop = !seen_ff || fgap_ff >= 42 * TC - 1;
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			fo_q_ff <= 1'b1;
			lm_q_ff <= 1'b0;
			seen_ff <= 1'b0;
			stop_ff <= 1'b1;
			sof0_ff <= 1'b0;
		end
		else
		begin
			fo_q_ff <= field_on;
			lm_q_ff <= load_mod;
			if (fell_now)
			begin
				seen_ff <= 1'b1;
				stop_ff <= is_stop;
				sof0_ff <= seen_ff && stop_ff && is_zero;
			end
		end
	end
	// Saturating, so long idle spans never wrap
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			fgap_ff <= 0;
			lgap_ff <= SAT;
		end
		else
		begin
			fgap_ff <= fell_now ? 0 : (fgap_ff < SAT ? fgap_ff + 1 : SAT);
			lgap_ff <= (lm_q_ff != load_mod) ? 0
				: (lgap_ff < SAT ? lgap_ff + 1 : SAT);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	off_len_a: assert property ($rose(field_on) && seen_ff
		|-> fgap_ff >= 4 * TC - 1 && fgap_ff <= 10 * TC)
		else $error("Carrier-off pulse length out of range");
	off_hold_a: assert property ($fell(field_on) |=> !field_on [*8])
		else $error("Carrier-off pulse too short");
	fall_window_a: assert property ($fell(field_on) && seen_ff
		|-> is_zero || is_stop || (fgap_ff >= 26 * TC - 1 && fgap_ff <= 30 * TC)
		|| (fgap_ff >= 34 * TC - 1 && fgap_ff <= 38 * TC))
		else $error("Edge interval outside every symbol window");
	frame_open_a: assert property ($fell(field_on)
		&& seen_ff && stop_ff |-> is_zero || is_stop)
		else $error("Frame does not open with a zero");
	sof_violation_a: assert property ($fell(field_on) && sof0_ff
		|-> fgap_ff >= 34 * TC - 1 && fgap_ff <= 38 * TC)
		else $error("Start zero not followed by a violation");
	settle_wait_a: assert property ($fell(field_on) && !seen_ff
		|-> fgap_ff >= SETTLE_WAIT_CYC - 2)
		else $error("First request before field settling");
	turnaround_a: assert property ($rose(load_mod) && lgap_ff > 64 * TC
		|-> fgap_ff >= 204 * TC - 1 && fgap_ff <= 213 * TC)
		else $error("Reply start outside turnaround window");
	manch_half_a: assert property ($changed(load_mod) && lgap_ff < 40 * TC
		|-> (lgap_ff >= 16 * TC - 2 && lgap_ff <= 16 * TC + 2)
		|| (lgap_ff >= 32 * TC - 2 && lgap_ff <= 32 * TC + 2))
		else $error("Uplink edge off the half-bit grid");
	reader_gap_a: assert property ($fell(field_on) |-> lgap_ff >= 150 * TC)
		else $error("Request too soon after uplink activity");
	cover property ($rose(load_mod) && lgap_ff > 64 * TC);
	cover property ($fell(field_on) && sof0_ff);
	cover property ($fell(field_on) && seen_ff && is_stop);
endmodule : lfc_link_asserts
`default_nettype wire

// *** dv/test_lf_tag_air_interface_codec.sv ***
// Bench: reader end and tag end on link 0; a lone tag end on link 1
// driven by the bench. Assumes package, interface and both ends compiled.
`timescale 1ns/1ns
`default_nettype none
module test_lf_tag_air_interface_codec;
	localparam int TC = lfc_pkg::TC_CYC;
	localparam int SETTLE = 200;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic req_start = 1'b0;
	logic [63:0] req_data = 64'h0;
	logic [7:0] req_len = 8'h0;
	logic req_ready;
	logic resp_end;
	logic [1:0] tx_start = 2'h0;
	logic [1:0] tx_ready;
	logic [1:0] tx_busy;
	logic [1:0] rx_sof;
	logic [1:0] rx_bv;
	logic [1:0] rx_bit;
	logic [1:0] rx_eof;
	logic [1:0] rx_err;
	lfc_pkg::lfc_code_t tx_code [2] = '{lfc_pkg::CODE_MANCH,
		lfc_pkg::CODE_BIPHASE};
	logic [1:0] slot_adv;
	int n_slot = 0;
	logic [63:0] tx_data [2] = '{64'h0, 64'h0};
	logic [7:0] tx_len [2] = '{8'h1, 8'h4};
	int n_sof [2] = '{0, 0};
	int n_err [2] = '{0, 0};
	int n_eof = 0;
	int n_rend = 0;
	int fails = 0;
	int samples_checked = 0;
	logic rxq [$];
	logic [31:0] rd;
	int unsigned rnd;
	lfc_link_if link [2] ();
	always #(lfc_pkg::CLK_NS / 2) ref_clk = ~ref_clk;
	lfc_reader_end #(
		.SETTLE_WAIT_CYC(SETTLE)
	) lfc_reader_end_inst (
		.ref_clk(ref_clk), .reset(reset), .link(link[0]),
		.req_start(req_start), .req_lone_eof(1'b0), .req_quiet(1'b0),
		.req_data(req_data), .req_len(req_len), .req_ready(req_ready),
		.resp_active(), .resp_end(resp_end)
	);
	for (genvar g = 0; g < 2; g++)
	begin : g_tag
		lfc_tag_end #(
			.NVM_WAIT_CYC(2000)
		) lfc_tag_end_inst (
			.ref_clk(ref_clk), .reset(reset), .link(link[g]),
			.rx_sof(rx_sof[g]), .rx_bit_valid(rx_bv[g]), .rx_bit(rx_bit[g]),
			.rx_eof(rx_eof[g]), .rx_err(rx_err[g]),
			.slot_advance(slot_adv[g]),
			.tx_start(tx_start[g]), .tx_code(tx_code[g]), .tx_nvm(1'b0),
			.tx_data(tx_data[g]), .tx_len(tx_len[g]),
			.tx_ready(tx_ready[g]), .tx_busy(tx_busy[g])
		);
	end
	lfc_link_asserts #(
		.SETTLE_WAIT_CYC(SETTLE)
	) lfc_link_asserts_inst (
		.ref_clk(ref_clk), .reset(reset),
		.field_on(link[0].field_on), .load_mod(link[0].load_mod)
	);
	always @(posedge ref_clk)
	begin
		for (int k = 0; k < 2; k++)
		begin
			n_sof[k] += int'(rx_sof[k] === 1'b1);
			n_err[k] += int'(rx_err[k] === 1'b1);
		end
		n_eof += int'(rx_eof[0] === 1'b1);
		n_slot += int'(slot_adv[1] === 1'b1);
		n_rend += int'(resp_end === 1'b1);
		if (rx_bv[0] === 1'b1)
			rxq.push_back(rx_bit[0]);
	end
	task automatic check_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit
	task automatic check_cnt(input string what, input int exp, input int got);
		samples_checked++;
		if (got != exp)
		begin
			fails++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_cnt
	// Level of half h: bi-phase from idle 0, else Manchester 1 = high, low
	function automatic logic half_level(input logic biph, input logic [3:0] b,
		input int h);
		logic lvl = 1'b0;
		for (int k = 0; k <= h; k++)
			lvl = (k % 2 == 0 || !b[k / 2]) ? ~lvl : lvl;
		return biph ? lvl : (h % 2 == 1 ? ~b[h / 2] : b[h / 2]);
	endfunction : half_level
	// Samples mid-half, so a few cycles of start skew do not matter
	task automatic check_reply(input int t, input logic [3:0] b);
		int n;
		for (n = 0; n < 70000 && tx_busy[t] !== 1'b1; n++)
			@(negedge ref_clk);
		repeat (8 * TC) @(negedge ref_clk);
		for (int h = 0; h < 8; h++)
		begin
			check_bit("load_mod", half_level(t == 1, b, h),
				t == 1 ? link[1].load_mod : link[0].load_mod);
			repeat (16 * TC) @(negedge ref_clk);
		end
		for (n = 0; n < 400 && tx_busy[t] !== 1'b0; n++)
			@(negedge ref_clk);
		check_bit("idle load_mod", 1'b0,
			t == 1 ? link[1].load_mod : link[0].load_mod);
	endtask : check_reply
	task automatic pulse_gap(input int gap);
		link[1].field_on <= 1'b0;
		repeat (lfc_pkg::PULSE_OFF_TC * TC) @(posedge ref_clk);
		link[1].field_on <= 1'b1;
		repeat ((gap - lfc_pkg::PULSE_OFF_TC) * TC) @(posedge ref_clk);
	endtask : pulse_gap
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	initial
	begin
		// Longest thread is the framed reply, near 90000 cycles
		repeat (95000) @(posedge ref_clk);
		fails++;
		stop_test();
	end
	initial
	begin
		link[1].field_on = 1'b1;
		rnd = $urandom(32'h6B22D86B);
		rd = $urandom();
		// Corner: both bit values appear in request and bi-phase reply
		rd[1:0] = 2'h2;
		rd[5:4] = 2'h2;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		fork
			begin
				for (int n = 0; n < 1000 && req_ready !== 1'b1; n++)
					@(posedge ref_clk);
				req_data <= {32'h0, rd};
				req_len <= 8'h03;
				tx_data[0] <= {63'h0, rd[8]};
				req_start <= 1'b1;
				tx_start[0] <= 1'b1;
				@(posedge ref_clk);
				req_start <= 1'b0;
				tx_start[0] <= 1'b0;
				@(negedge ref_clk);
				check_bit("tx_ready", 1'b0, tx_ready[0]);
				check_reply(0, {rd[8], 3'h3});
				check_cnt("rx_bit count", 3, rxq.size());
				for (int i = 0; i < 3; i++)
					check_bit("rx_bit", rd[i], rxq[i]);
				check_cnt("rx_sof", 1, n_sof[0]);
				check_cnt("rx_eof", 1, n_eof);
				check_cnt("rx_err clean", 0, n_err[0]);
				repeat (80 * TC) @(negedge ref_clk);
				check_cnt("resp_end", 1, n_rend);
			end
			begin
				@(posedge ref_clk);
				tx_data[1] <= {60'h0, rd[7:4]};
				tx_start[1] <= 1'b1;
				@(posedge ref_clk);
				tx_start[1] <= 1'b0;
				check_reply(1, rd[7:4]);
				@(posedge ref_clk);
				pulse_gap(lfc_pkg::ZERO_TX_TC);
				pulse_gap(lfc_pkg::CV_TX_TC);
				pulse_gap(24);
				pulse_gap(50);
				check_cnt("rx_sof lone", 1, n_sof[1]);
				check_cnt("rx_err bad gap", 1, n_err[1]);
				check_cnt("slot_advance early", 0, n_slot);
				// Lone end-of-frame pulse, then the slot turnaround
				pulse_gap(lfc_pkg::TFP1_MAX_TC + 4);
				check_cnt("slot_advance", 1, n_slot);
			end
		join
		stop_test();
	end
endmodule : test_lf_tag_air_interface_codec
`default_nettype wire
